// file: pkg/lprs_map.svh
// Register map, field positions, reset values and timing counts
`ifndef LPRS_MAP_SVH
`define LPRS_MAP_SVH

// Register byte addresses
`define ADR_BREAK_STATUS    16'hfe00
`define ADR_RESET_CAUSE     16'hfe01
`define ADR_BREAK_FLAG_CTRL 16'hfe03

// Break status fields
`define BIT_BREAK_EXITED_WAIT 1

// Reset cause fields
`define BIT_POR            7
`define BIT_PIN            6
`define BIT_WATCHDOG       5
`define BIT_ILLEGAL_OPCODE 4
`define BIT_ILLEGAL_ADDR   3
`define BIT_MONITOR_ENTRY  2
`define BIT_LOW_VOLTAGE    1

// Break flag control fields
`define BIT_BREAK_CLEAR_EN 7

// Reset values
`define RST_BREAK_STATUS    8'h00
`define RST_RESET_CAUSE_POR 8'h80
`define RST_BREAK_FLAG_CTRL 8'h00
`define RST_READ_DATA       8'h00

// Erased flash byte seen in both reset vector bytes
`define ERASED_BYTE 8'hff

// Stop recovery lengths in crystal clock cycles
`define STOP_REC_LONG_XCYC  4096
`define STOP_REC_SHORT_XCYC 32

// Bus cycles from the wait wake cycle to interrupt stacking
`define WAIT_STACK_DELAY_CYC 1

`endif

// file: pkg/lprs_pkg.sv
// Types shared by the low-power and reset status logic
package lprs_pkg;

  // Operating mode of the core clock controller
  typedef enum logic [1:0] {
    MODE_RUN     = 2'b00,
    MODE_WAIT    = 2'b01,
    MODE_STOP    = 2'b10,
    MODE_RECOVER = 2'b11
  } lp_mode_t;

  // Low-power instruction strobes from the core
  typedef struct packed {
    logic wait_exec;
    logic stop_exec;
  } cpu_req_t;

  // Reset sources other than power-on, one-cycle pulses
  typedef struct packed {
    logic pin;
    logic watchdog;
    logic illegal_opcode;
    logic illegal_addr;
    logic opcode_fetch;
    logic low_voltage;
    logic monitor_enter;
  } rst_ev_t;

  // Conditions for monitor mode entry after power-on
  typedef struct packed {
    logic [7:0] vector_hi;
    logic [7:0] vector_lo;
    logic       irq_at_supply;
  } monitor_cond_t;

  // Clock gates towards core and peripherals
  typedef struct packed {
    logic cpu;
    logic bus_clock_out;
    logic crystal_clock_out;
  } clk_gate_t;

endpackage : lprs_pkg

// file: src/low_power_and_reset_status_ctrl.sv
// Wait/stop control, reset cause and break status registers
//
// Behaviour
// - Wait stops core clock, peripherals keep running.
// - Wait interrupt wakes; stacking one cycle later.
// - Wait ends on reset, or break in emulation.
// - Break exit from wait sets status flag.
// - Watchdog runs in wait unless option disables.
// - Stop clears counter and gates both clocks.
// - Stop ends on interrupt or reset; stack after recovery.
// - Recovery 4096 crystal cycles, 32 when short.
// - Counter held from stop until recovery starts.
// - Registers at fe00, fe01, fe03; fe02 unmapped.
// - Break flag reads one after break exit.
// - Reset cause shows last reset; read clears.
// - Power-on sets its flag, clears others.
// - Pin, watchdog, opcode, voltage flags; read clears.
// - Illegal address flag only for opcode fetch.
// - Monitor flag: erased vector, interrupt pin high.
// - Break clear enable decides clearing during break.
// - Second clear step after break clears normally.
// - Wait or stop clears core interrupt mask.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`include "lprs_map.svh"

module low_power_and_reset_status_ctrl #(
  parameter int LONG_REC_XCYC  = `STOP_REC_LONG_XCYC,
  parameter int SHORT_REC_XCYC = `STOP_REC_SHORT_XCYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave, 8-bit data
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [15:0]             adr_i,
  input  wire logic [7:0]              dat_i,
  input  wire logic                    sel_i,
  output logic [7:0]                   dat_o,
  output logic                         ack_o,
  // Core and module side
  input  wire lprs_pkg::cpu_req_t      cpu_req_i,
  input  wire logic                    irq_req_i,
  input  wire logic                    break_req_i,
  input  wire logic                    emulation_i,
  input  wire logic                    break_state_i,
  input  wire lprs_pkg::rst_ev_t       rst_ev_i,
  input  wire lprs_pkg::monitor_cond_t mon_i,
  input  wire logic                    short_recovery_option_i,
  input  wire logic                    watchdog_disable_option_i,
  input  wire logic                    xtal_clk_i,
  output lprs_pkg::clk_gate_t          clk_gate_o,
  output lprs_pkg::lp_mode_t           mode_o,
  output logic                         stack_start_o,
  output logic                         clear_imask_o,
  output logic                         watchdog_run_o,
  output logic                         status_clear_permit_o
);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  lprs_pkg::lp_mode_t mode_reg;
  lprs_pkg::lp_mode_t mode_next;

  logic       any_reset;
  logic       wait_wake;
  logic       wait_break;
  logic       stop_wake;
  logic       rec_hold;
  logic       rec_done;
  logic       clear_permit;

  logic       bus_req;
  logic       ack_reg;
  logic       bus_done;
  logic       wr_done;
  logic       rd_done;
  logic [7:0] rd_data;
  logic [7:0] dat_reg;

  logic       exited_wait_reg;
  logic       exited_wait_next;
  logic [7:0] bfc_reg;
  logic [7:0] cause;
  logic       cause_rd_clr;

  logic       stack_reg;
  logic       imask_reg;

  // Register select, used by the read mux and by the write paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_adr);
    hit = (a == reg_adr);
  endfunction : hit

  // -----------------------------------------------------------------
  // Wake and exit conditions
  // -----------------------------------------------------------------
  // Any non power-on reset source ends a low-power mode
  assign any_reset = rst_ev_i.pin | rst_ev_i.watchdog | rst_ev_i.illegal_opcode
                   | (rst_ev_i.illegal_addr & rst_ev_i.opcode_fetch)
                   | rst_ev_i.low_voltage | rst_ev_i.monitor_enter;

  assign wait_wake  = (mode_reg == lprs_pkg::MODE_WAIT) & irq_req_i & ~any_reset;
  // Break wakes only in emulation; a reset in the same cycle takes over
  assign wait_break = (mode_reg == lprs_pkg::MODE_WAIT) & break_req_i
                    & emulation_i & ~any_reset & ~irq_req_i;
  assign stop_wake  = (mode_reg == lprs_pkg::MODE_STOP) & irq_req_i;

  // -----------------------------------------------------------------
  // Mode sequencer
  // -----------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      lprs_pkg::MODE_RUN: begin
        if (cpu_req_i.stop_exec) begin
          mode_next = lprs_pkg::MODE_STOP;
        end else if (cpu_req_i.wait_exec) begin
          mode_next = lprs_pkg::MODE_WAIT;
        end
      end
      lprs_pkg::MODE_WAIT: begin
        if (any_reset || irq_req_i) begin
          mode_next = lprs_pkg::MODE_RUN;
        end else if (break_req_i && emulation_i) begin
          mode_next = lprs_pkg::MODE_RUN;
        end
      end
      lprs_pkg::MODE_STOP: begin
        if (any_reset) begin
          mode_next = lprs_pkg::MODE_RUN;
        end else if (irq_req_i) begin
          mode_next = lprs_pkg::MODE_RECOVER;
        end
      end
      lprs_pkg::MODE_RECOVER: begin
        if (any_reset || rec_done) begin
          mode_next = lprs_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_next = lprs_pkg::MODE_RUN;
      end
    endcase
  end

  // Mode state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= lprs_pkg::MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign mode_o = mode_reg;

  // -----------------------------------------------------------------
  // Stop recovery timing
  // -----------------------------------------------------------------
  // Counter stays cleared outside recovery, so each stop starts from zero
  assign rec_hold = (mode_reg != lprs_pkg::MODE_RECOVER);

  stop_recovery_timer #(
    .LONG_CYC  (LONG_REC_XCYC),
    .SHORT_CYC (SHORT_REC_XCYC)
  ) u_rec (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .xtal_clk_i (xtal_clk_i),
    .hold_i     (rec_hold),
    .short_i    (short_recovery_option_i),
    .done_o     (rec_done)
  );

  // -----------------------------------------------------------------
  // Clock gates and watchdog
  // -----------------------------------------------------------------
  // Core runs only in run mode; oscillator output waits for recovery
  always_comb begin
    clk_gate_o.cpu               = (mode_reg == lprs_pkg::MODE_RUN);
    clk_gate_o.bus_clock_out     = (mode_reg == lprs_pkg::MODE_RUN)
                                 | (mode_reg == lprs_pkg::MODE_WAIT);
    clk_gate_o.crystal_clock_out = (mode_reg == lprs_pkg::MODE_RUN)
                                 | (mode_reg == lprs_pkg::MODE_WAIT);
  end

  // Watchdog halts with the clocks in stop, keeps going in wait
  assign watchdog_run_o = ~watchdog_disable_option_i
                        & ((mode_reg == lprs_pkg::MODE_RUN)
                        |  (mode_reg == lprs_pkg::MODE_WAIT));

  // -----------------------------------------------------------------
  // Core strobes
  // -----------------------------------------------------------------
  // Stacking pulse: one cycle after a wait wake, or at recovery end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_reg <= 1'b0;
    end else begin
      stack_reg <= wait_wake
                 | ((mode_reg == lprs_pkg::MODE_RECOVER) & rec_done & ~any_reset);
    end
  end

  // Mask clear follows either low-power instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imask_reg <= 1'b0;
    end else begin
      imask_reg <= (mode_reg == lprs_pkg::MODE_RUN)
                 & (cpu_req_i.wait_exec | cpu_req_i.stop_exec);
    end
  end

  assign stack_start_o = stack_reg;
  assign clear_imask_o = imask_reg;

  // -----------------------------------------------------------------
  // Break flag protection
  // -----------------------------------------------------------------
  // Modules gate the final step of any clear with this, so a first
  // step taken before break cannot complete during break unless clear enable is set
  assign clear_permit = ~break_state_i | bfc_reg[`BIT_BREAK_CLEAR_EN];
  assign status_clear_permit_o = clear_permit;

  // -----------------------------------------------------------------
  // Wishbone slave
  // -----------------------------------------------------------------
  // One wait state: ack rises the cycle after the strobe, drops after
  assign bus_req  = cyc_i & stb_i;
  assign bus_done = bus_req & ack_reg;
  assign wr_done  = bus_done & we_i & sel_i;
  assign rd_done  = bus_done & ~we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  // Read mux; fe02 and all other addresses read as zero
  always_comb begin
    rd_data = `RST_READ_DATA;
    if (hit(adr_i, `ADR_BREAK_STATUS)) begin
      rd_data[`BIT_BREAK_EXITED_WAIT] = exited_wait_reg;
    end else if (hit(adr_i, `ADR_RESET_CAUSE)) begin
      rd_data = cause;
    end else if (hit(adr_i, `ADR_BREAK_FLAG_CTRL)) begin
      rd_data = bfc_reg;
    end
  end

  // Read data captured while the flags still hold their old values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= `RST_READ_DATA;
    end else if (bus_req && !ack_reg && !we_i) begin
      dat_reg <= rd_data;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // -----------------------------------------------------------------
  // Break flag control register
  // -----------------------------------------------------------------
  // Only the clear enable bit is implemented; others read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bfc_reg <= `RST_BREAK_FLAG_CTRL;
    end else if (wr_done && hit(adr_i, `ADR_BREAK_FLAG_CTRL)) begin
      bfc_reg <= 8'h00;
      bfc_reg[`BIT_BREAK_CLEAR_EN] <= dat_i[`BIT_BREAK_CLEAR_EN];
    end
  end

  // -----------------------------------------------------------------
  // Break status register
  // -----------------------------------------------------------------
  // Writing zero clears the flag; a break exit in that cycle still sets it
  always_comb begin
    exited_wait_next = exited_wait_reg;
    if (wr_done && hit(adr_i, `ADR_BREAK_STATUS) && clear_permit
        && !dat_i[`BIT_BREAK_EXITED_WAIT]) begin
      exited_wait_next = 1'b0;
    end
    if (wait_break) begin
      exited_wait_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exited_wait_reg <= 1'(`RST_BREAK_STATUS >> `BIT_BREAK_EXITED_WAIT);
    end else begin
      exited_wait_reg <= exited_wait_next;
    end
  end

  // -----------------------------------------------------------------
  // Reset cause register
  // -----------------------------------------------------------------
  // Clear lands on the acknowledge edge, after data was captured
  assign cause_rd_clr = rd_done & hit(adr_i, `ADR_RESET_CAUSE) & clear_permit;

  reset_cause_log u_cause (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ev_i     (rst_ev_i),
    .mon_i    (mon_i),
    .rd_clr_i (cause_rd_clr),
    .cause_o  (cause)
  );

endmodule : low_power_and_reset_status_ctrl

// file: src/reset_cause_log.sv
// Reset cause flags, set by reset sources and cleared by a read
`timescale 1ns/1ps
`include "lprs_map.svh"

module reset_cause_log (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire lprs_pkg::rst_ev_t      ev_i,
  input  wire lprs_pkg::monitor_cond_t mon_i,
  input  wire logic                   rd_clr_i,
  output logic [7:0]                  cause_o
);

  logic [7:0] cause_reg;
  logic [7:0] cause_next;

  // Monitor entry only counts with an erased reset vector and the pin high
  function automatic logic monitor_ok(input lprs_pkg::monitor_cond_t m);
    monitor_ok = (m.vector_hi == `ERASED_BYTE) && (m.vector_lo == `ERASED_BYTE) && m.irq_at_supply;
  endfunction : monitor_ok

  // -----------------------------------------------------------------
  // Next flag values
  // -----------------------------------------------------------------
  // A new reset in the read cycle survives the clear
  always_comb begin
    cause_next = rd_clr_i ? 8'h00 : cause_reg;
    if (ev_i.pin)            cause_next[`BIT_PIN]            = 1'b1;
    if (ev_i.watchdog)       cause_next[`BIT_WATCHDOG]       = 1'b1;
    if (ev_i.illegal_opcode) cause_next[`BIT_ILLEGAL_OPCODE] = 1'b1;
    if (ev_i.low_voltage)    cause_next[`BIT_LOW_VOLTAGE]    = 1'b1;
    if (ev_i.illegal_addr && ev_i.opcode_fetch) begin
      cause_next[`BIT_ILLEGAL_ADDR] = 1'b1;
    end
    if (ev_i.monitor_enter && monitor_ok(mon_i)) begin
      cause_next[`BIT_MONITOR_ENTRY] = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Flag register
  // -----------------------------------------------------------------
  // Power-on leaves only its own flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_reg <= `RST_RESET_CAUSE_POR;
    end else begin
      cause_reg <= cause_next;
    end
  end

  assign cause_o = cause_reg;

endmodule : reset_cause_log

// file: src/stop_recovery_timer.sv
// Stop recovery timer counting crystal clock edges
`timescale 1ns/1ps
`include "lprs_map.svh"

module stop_recovery_timer #(
  parameter int LONG_CYC  = `STOP_REC_LONG_XCYC,
  parameter int SHORT_CYC = `STOP_REC_SHORT_XCYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic xtal_clk_i,
  input  wire logic hold_i,
  input  wire logic short_i,
  output logic      done_o
);

  localparam int CW = $clog2(LONG_CYC + 1);

  logic          xs1_reg;
  logic          xs2_reg;
  logic          xs3_reg;
  logic          tick;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] target;

  // -----------------------------------------------------------------
  // Crystal clock sampling
  // -----------------------------------------------------------------
  // Two stages before any logic; crystal must stay below half bus rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xs1_reg <= 1'b0;
      xs2_reg <= 1'b0;
      xs3_reg <= 1'b0;
    end else begin
      xs1_reg <= xtal_clk_i;
      xs2_reg <= xs1_reg;
      xs3_reg <= xs2_reg;
    end
  end

  assign tick = xs2_reg & ~xs3_reg;

  // -----------------------------------------------------------------
  // Recovery count
  // -----------------------------------------------------------------
  assign target = short_i ? CW'(SHORT_CYC) : CW'(LONG_CYC);

  // Held at zero until recovery starts, then counts crystal edges
  always_ff @(posedge clk_i) begin
    if (rst_i || hold_i) begin
      count_reg <= '0;
    end else if (tick && (count_reg < target)) begin
      count_reg <= count_reg + CW'(1);
    end
  end

  assign done_o = ~hold_i & (count_reg >= target);

endmodule : stop_recovery_timer

// file: tb/core_model.sv
// Behavioural model of the core and the peripheral modules
`timescale 1ns/1ps

module core_model (
  input  wire logic               clk_i,
  input  wire lprs_pkg::lp_mode_t mode_i,
  input  wire logic               stack_start_i,
  output lprs_pkg::cpu_req_t      cpu_req_o,
  output logic                    irq_req_o,
  output logic                    break_req_o,
  output logic                    xtal_clk_o
);
  // ----
  // Stimulus
  // ----
  // Crystal runs free at 2.5 MHz, offset so its edges never meet the bus clock's
  initial begin
    cpu_req_o = '0;
    irq_req_o = 1'b0;
    break_req_o = 1'b0;
    xtal_clk_o = 1'b0;
    #13;
    forever #200 xtal_clk_o = ~xtal_clk_o;
  end

  // One instruction strobe per low-power entry
  task automatic exec(input logic stop);
    @(posedge clk_i);
    cpu_req_o <= stop ? 2'b01 : 2'b10;
    @(posedge clk_i);
    cpu_req_o <= '0;
  endtask : exec

  task automatic wake();
    @(posedge clk_i);
    irq_req_o <= 1'b1;
  endtask : wake

  task automatic brk();
    @(posedge clk_i);
    break_req_o <= 1'b1;
  endtask : brk

  // A source holds its request until serviced; break drops once wait has ended
  always @(posedge clk_i) begin
    if (stack_start_i)
      irq_req_o <= 1'b0;
    if (mode_i != lprs_pkg::MODE_WAIT)
      break_req_o <= 1'b0;
  end
endmodule : core_model

// file: tb/low_power_and_reset_status_ctrl_tb.sv
// Self-checking bench for the low-power and reset status block
`timescale 1ns/1ps
`include "lprs_map.svh"

module low_power_and_reset_status_ctrl_tb;
  localparam int LONG_REC = 64;
  logic                    clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sel_i = 0;
  logic [15:0]             adr_i = '0;
  logic [7:0]              dat_i = '0, dat_o, rd;
  logic                    ack_o, stack_start_o, clear_imask_o, watchdog_run_o, status_clear_permit_o;
  logic                    irq_req_i, break_req_i, xtal_clk_i, emulation_i = 0, break_state_i = 0;
  logic                    short_recovery_option_i = 0, watchdog_disable_option_i = 0;
  lprs_pkg::cpu_req_t      cpu_req_i;
  lprs_pkg::rst_ev_t       rst_ev_i = '0;
  lprs_pkg::monitor_cond_t mon_i = 17'h1ffff;
  lprs_pkg::clk_gate_t     clk_gate_o;
  lprs_pkg::lp_mode_t      mode_o;
  int                      num_errors = 0, comparisons = 0;

  low_power_and_reset_status_ctrl #(.LONG_REC_XCYC(LONG_REC), .SHORT_REC_XCYC(32)) u_dut (.clk_i, .rst_i,
    .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o, .cpu_req_i, .irq_req_i, .break_req_i,
    .emulation_i, .break_state_i, .rst_ev_i, .mon_i, .short_recovery_option_i, .watchdog_disable_option_i,
    .xtal_clk_i, .clk_gate_o, .mode_o, .stack_start_o, .clear_imask_o, .watchdog_run_o,
    .status_clear_permit_o);
  core_model u_core (.clk_i, .mode_i(mode_o), .stack_start_i(stack_start_o), .cpu_req_o(cpu_req_i),
    .irq_req_o(irq_req_i), .break_req_o(break_req_i), .xtal_clk_o(xtal_clk_i));

  // ----
  // Helpers
  // ----
  always #25 clk_i = ~clk_i;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, sel_i} <= 3'b111;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    {cyc_i, stb_i, sel_i, we_i} <= 4'h0;
    if (ack_o !== 1'b1) begin
      num_errors++;
      close_out();
    end
  endtask : bus

  task automatic pulse(input lprs_pkg::rst_ev_t v);
    @(posedge clk_i);
    rst_ev_i <= v;
    @(posedge clk_i);
    rst_ev_i <= '0;
  endtask : pulse

  task automatic wait_stack(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (stack_start_o !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      num_errors++;
      close_out();
    end
  endtask : wait_stack

  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    bus(0, `ADR_RESET_CAUSE, 8'h00);
    chk(rd, `RST_RESET_CAUSE_POR);
    bus(0, `ADR_RESET_CAUSE, 8'h00);
    chk(rd, 8'h00);
    bus(0, `ADR_BREAK_STATUS, 8'h00);
    chk(rd, 8'h00);
    bus(1, 16'hfe02, 8'hff);
    bus(0, 16'hfe02, 8'h00);
    chk(rd, 8'h00);
    bus(0, `ADR_BREAK_FLAG_CTRL, 8'h00);
    chk(rd, 8'h00);
    bus(1, `ADR_BREAK_FLAG_CTRL, 8'h80);
    bus(0, `ADR_BREAK_FLAG_CTRL, 8'h00);
    chk(rd, 8'h80);
    bus(1, `ADR_BREAK_FLAG_CTRL, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // Each source alone; the read in between must have cleared the last one
  task automatic t_causes();
    lprs_pkg::rst_ev_t ev_tab [7] = '{7'h40, 7'h20, 7'h10, 7'h0c, 7'h08, 7'h02, 7'h01};
    logic [7:0]        exp_tab [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h00, 8'h02, 8'h04};
    for (int i = 0; i < 7; i++) begin
      pulse(ev_tab[i]);
      bus(0, `ADR_RESET_CAUSE, 8'h00);
      chk(rd, exp_tab[i]);
    end
    mon_i <= 17'h1feff;
    pulse(7'h01);
    bus(0, `ADR_RESET_CAUSE, 8'h00);
    chk(rd, 8'h00);
    mon_i <= 17'h1ffff;
    $display("test causes done");
  endtask : t_causes

  task automatic t_wait();
    int n;
    u_core.exec(0);
    @(posedge clk_i);
    chk(8'(mode_o), 8'(lprs_pkg::MODE_WAIT));
    chk(8'(clear_imask_o), 8'h01);
    chk(8'(clk_gate_o), 8'h03);
    chk(8'(watchdog_run_o), 8'h01);
    watchdog_disable_option_i <= 1'b1;
    u_core.wake();
    wait_stack(n);
    chk(8'(watchdog_run_o), 8'h00);
    chk(8'(n), 8'h02);
    chk(8'(mode_o), 8'(lprs_pkg::MODE_RUN));
    $display("test wait done");
  endtask : t_wait

  task automatic t_break();
    emulation_i <= 1'b1;
    u_core.exec(0);
    u_core.brk();
    repeat (2) @(posedge clk_i);
    chk(8'(mode_o), 8'(lprs_pkg::MODE_RUN));
    chk(8'(stack_start_o), 8'h00);
    emulation_i <= 1'b0;
    bus(0, `ADR_BREAK_STATUS, 8'h00);
    chk(rd, 8'h02);
    bus(1, `ADR_BREAK_STATUS, 8'h00);
    bus(0, `ADR_BREAK_STATUS, 8'h00);
    chk(rd, 8'h00);
    // Flags survive reads during break until clearing is enabled
    pulse(7'h40);
    break_state_i <= 1'b1;
    @(posedge clk_i);
    chk(8'(status_clear_permit_o), 8'h00);
    bus(0, `ADR_RESET_CAUSE, 8'h00);
    chk(rd, 8'h40);
    bus(0, `ADR_RESET_CAUSE, 8'h00);
    chk(rd, 8'h40);
    bus(1, `ADR_BREAK_FLAG_CTRL, 8'h80);
    @(posedge clk_i);
    chk(8'(status_clear_permit_o), 8'h01);
    bus(0, `ADR_RESET_CAUSE, 8'h00);
    bus(0, `ADR_RESET_CAUSE, 8'h00);
    chk(rd, 8'h00);
    break_state_i <= 1'b0;
    bus(1, `ADR_BREAK_FLAG_CTRL, 8'h00);
    $display("test break done");
  endtask : t_break

  // Crystal period is eight bus cycles; allow edge phase plus synchroniser
  task automatic t_stop(input logic sh, input int rec);
    int n;
    short_recovery_option_i <= sh;
    u_core.exec(1);
    @(posedge clk_i);
    chk(8'(clk_gate_o), 8'h00);
    chk(8'(clear_imask_o), 8'h01);
    repeat (20) @(posedge clk_i);
    chk(8'(mode_o), 8'(lprs_pkg::MODE_STOP));
    u_core.wake();
    wait_stack(n);
    chk(8'(n >= rec * 8 - 8 && n <= rec * 8 + 12), 8'h01);
    short_recovery_option_i <= 1'b0;
    $display("test stop done");
  endtask : t_stop

  task automatic t_stop_reset();
    u_core.exec(1);
    pulse(7'h40);
    @(posedge clk_i);
    chk(8'(mode_o), 8'(lprs_pkg::MODE_RUN));
    bus(0, `ADR_RESET_CAUSE, 8'h00);
    chk(rd, 8'h40);
    $display("test stop reset done");
  endtask : t_stop_reset

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_causes();
    t_wait();
    t_break();
    t_stop(1'b0, LONG_REC);
    t_stop(1'b1, 32);
    t_stop_reset();
    close_out();
  end
endmodule : low_power_and_reset_status_ctrl_tb

// file: tb/lprs_properties.sv
// Port checker for the low-power and reset status block
`timescale 1ns/1ps

module lprs_properties #(
  parameter int LONG_REC_XCYC  = 4096,
  parameter int SHORT_REC_XCYC = 32
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                we_i,
  input wire logic [15:0]         adr_i,
  input wire logic [7:0]          dat_o,
  input wire logic                ack_o,
  input wire lprs_pkg::cpu_req_t  cpu_req_i,
  input wire logic                irq_req_i,
  input wire logic                break_state_i,
  input wire lprs_pkg::rst_ev_t   rst_ev_i,
  input wire logic                watchdog_disable_option_i,
  input wire lprs_pkg::clk_gate_t clk_gate_o,
  input wire lprs_pkg::lp_mode_t  mode_o,
  input wire logic                stack_start_o,
  input wire logic                clear_imask_o,
  input wire logic                watchdog_run_o,
  input wire logic                status_clear_permit_o
);
  // ----
  // Properties
  // ----
  // One domain only, so clock and reset are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer not a single pulse one cycle after the request");
  unmapped_read_a: assert property (ack_o && !we_i && adr_i == 16'hfe02 |-> dat_o == 8'h00)
    else $error("unmapped read returned data");
  wait_entry_a: assert property (mode_o == lprs_pkg::MODE_RUN && cpu_req_i == 2'b10
    |=> mode_o == lprs_pkg::MODE_WAIT && clear_imask_o) else $error("wait entry wrong");
  wait_gate_a: assert property (mode_o == lprs_pkg::MODE_WAIT |-> clk_gate_o == 3'b011)
    else $error("wait clock gates wrong");
  wait_wake_a: assert property (mode_o == lprs_pkg::MODE_WAIT && irq_req_i && rst_ev_i == '0
    |=> mode_o == lprs_pkg::MODE_RUN && stack_start_o) else $error("wait wake late");
  reset_exit_a: assert property (mode_o != lprs_pkg::MODE_RUN && rst_ev_i.pin
    |=> mode_o == lprs_pkg::MODE_RUN && !stack_start_o) else $error("reset did not end low power");
  stop_gate_a: assert property (mode_o == lprs_pkg::MODE_STOP |-> clk_gate_o == 3'b000)
    else $error("clock running in stop");
  recover_hold_a: assert property ($rose(mode_o == lprs_pkg::MODE_RECOVER) |-> !stack_start_o [*8])
    else $error("stacking inside recovery");
  watchdog_wait_a: assert property (mode_o == lprs_pkg::MODE_WAIT && !watchdog_disable_option_i
    |-> watchdog_run_o) else $error("watchdog halted in wait");
  clear_permit_a: assert property (!break_state_i |-> status_clear_permit_o)
    else $error("clearing blocked outside break");
endmodule : lprs_properties

bind low_power_and_reset_status_ctrl lprs_properties #(
  .LONG_REC_XCYC(LONG_REC_XCYC),
  .SHORT_REC_XCYC(SHORT_REC_XCYC)
) u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .cpu_req_i, .irq_req_i,
  .break_state_i, .rst_ev_i, .watchdog_disable_option_i, .clk_gate_o, .mode_o, .stack_start_o,
  .clear_imask_o, .watchdog_run_o, .status_clear_permit_o);
